// ===== src/apseq_map.vh
/*
 * Register map, field positions, reset values and gain table constants of the
 * amplifier and power sequencing block.
 * Assumes it is included by bare name from design files under src/.
 */
`ifndef APSEQ_MAP_VH
`define APSEQ_MAP_VH

// Byte addresses on the APB (register index times four).
`define APSEQ_IDX_AMP_CTRL      8'h11
`define APSEQ_ADDR_AMP_CTRL     12'h044
`define APSEQ_IDX_PRECH         8'h0C
`define APSEQ_ADDR_PRECH        12'h030
`define APSEQ_IDX_POWER         8'h00
`define APSEQ_ADDR_POWER        12'h000
`define APSEQ_IDX_RESET         8'h10
`define APSEQ_ADDR_RESET        12'h040
`define APSEQ_ADDR_STATUS       12'h048
`define APSEQ_ADDR_CHARGE       12'h04C

// Amplifier control fields.
`define APSEQ_AMP_ON_BIT        6
`define APSEQ_AMP_PRECH_BIT     5
`define APSEQ_AMP_LP_BIT        4
`define APSEQ_AMP_GAIN_MSB      3
`define APSEQ_AMP_CTRL_RST      7'h00
`define APSEQ_AMP_CTRL_MASK     8'h7F

// Fastcharge register fields.
`define APSEQ_PRECH_ON_MSTR     0
`define APSEQ_PRECH_MSTR        1
`define APSEQ_PRECH_LNIL        2
`define APSEQ_PRECH_LNIR        3
`define APSEQ_PRECH_LNOL        4
`define APSEQ_PRECH_LNOR        5
`define APSEQ_PRECH_AUXIN       6
`define APSEQ_PRECH_PADRV       7
`define APSEQ_PRECH_RST         8'h00

// Power register fields.
`define APSEQ_PWR_LNIL          0
`define APSEQ_PWR_LNIR          1
`define APSEQ_PWR_DACL          2
`define APSEQ_PWR_DACR          3
`define APSEQ_PWR_LNOL          4
`define APSEQ_PWR_LNOR          5
`define APSEQ_PWR_AUXIN         6
`define APSEQ_PWR_PADRV         7
`define APSEQ_PWR_RST           8'h00

// Codec reset register fields.
`define APSEQ_RST_CODEC_N       0
`define APSEQ_RST_FILTER_N      1
`define APSEQ_RST_MASK          2
`define APSEQ_RST_RST           3'h0

// Gain table: code 0 and code 15 both give the minimum gain.
`define APSEQ_GAIN_MIN_DB       8'hEA
`define APSEQ_GAIN_TOP_DB       8'h14
`define APSEQ_GAIN_STEP_DB      8'h03

`endif

// ===== src/apseq_charge.v
/*
 * One fastcharge channel: tracks a block from off through charging to ready.
 * Assumes power and fastcharge enables are register bits on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module apseq_charge
(
    input  wire clk,
    input  wire rst,
    input  wire power_on,
    input  wire fastcharge,
    output wire charging,
    output wire ready
);

    reg charging_ff;
    reg ready_ff;
    reg nxt_charging;
    reg nxt_ready;

    // Charging starts once power rises while fastcharge is set, and ends
    // when software drops fastcharge; losing power undoes everything.
    always @*
    begin
        nxt_charging = charging_ff;
        nxt_ready    = ready_ff;
        if (!power_on)
        begin
            nxt_charging = 1'b0;   // see R13
            nxt_ready    = 1'b0;
        end
        else if (charging_ff && !fastcharge)
        begin
            nxt_charging = 1'b0;   // see R13
            nxt_ready    = 1'b1;
        end
        else if (!charging_ff && !ready_ff && fastcharge)
        begin
            nxt_charging = 1'b1;   // see R13
        end
    end

    // State flops.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            charging_ff <= 1'b0;
            ready_ff    <= 1'b0;
        end
        else
        begin
            charging_ff <= nxt_charging;
            ready_ff    <= nxt_ready;
        end
    end

    assign charging = charging_ff;
    assign ready    = ready_ff;

endmodule

`default_nettype wire

// ===== src/apseq_top.v
/*
 * Audio amplifier control and analog power sequencing registers on APB.
 * Holds the amplifier control word, fastcharge and power bits, codec
 * resets, and per block charge state.
 * Assumes one clock and an APB master on that clock; every access is
 * answered in its first access cycle, with no wait state.
 */
// How it works
// R1: Bit 6 is amp_on, and with bit 5 it selects standby, input precharge or active mode.
// R2: Software never sets amp_on and amp_input_precharge together; the block flags that case.
// R3: Bit 4 is amp_power_level, 0 for low power and 1 for high power.
// R4: Bits 3 to 0 hold amp_gain_code, the amplifier's programmable gain.
// R5: Gain codes 0 and 15 give -22 dB, code 1 gives +20 dB, and each next code 3 dB less.
// R6: Amplifier control resets to zero, so standby, low power and gain code zero.
// R7: Software powers the converter-to-headset path by a timed sequence of writes.
// R8: Software powers that path down by a timed sequence of writes.
// R9: Software starts serial audio by reset mask, reset pulse, wait, then converters on.
// R10: Software clears both converter power bits before it stops the serial stream.
// R11: Software runs input precharge before it enables the amplifier.
// R12: Software sets the minimum gain before it switches the amplifier off.
// R13: A block charges from its power bit rising with fastcharge set until fastcharge clears.
// R14: Clearing a power bit demands a fresh fastcharge then power sequence.
// R15: Reference, line, aux and driver blocks pair power with fastcharge; converters power only.
// R16: Any number of blocks may charge at once, in no set order.
`timescale 1ns/1ps
`default_nettype none

`include "apseq_map.vh"

module apseq_top
(
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output reg         amp_active,
    output reg         amp_precharging,
    output reg         amp_high_power,
    output reg  [3:0]  amp_gain_code,
    output reg  [7:0]  amp_gain_db,
    output reg         amp_forbidden,
    output reg  [7:0]  block_power_en,
    output reg  [5:0]  block_charging,
    output reg         codec_reset_n,
    output reg         filter_reset_n,
    output reg         codec_reset_mask
);

    localparam NBLK = 7;

    reg  [6:0]  amplifier_control_ff;
    reg  [7:0]  prech_ff;
    reg  [7:0]  power_ff;
    reg  [2:0]  reset_ff;
    reg  [7:0]  nxt_gain_db;
    reg  [31:0] nxt_prdata;
    wire [6:0]  chg_power;
    wire [6:0]  chg_fast;
    wire [6:0]  chg_busy;
    wire [6:0]  chg_ready;
    wire        wr_en;
    wire        hit;

    // Zero wait state slave: every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign hit     = (paddr == `APSEQ_ADDR_AMP_CTRL) || (paddr == `APSEQ_ADDR_PRECH)
                   || (paddr == `APSEQ_ADDR_POWER) || (paddr == `APSEQ_ADDR_RESET)
                   || (paddr == `APSEQ_ADDR_STATUS) || (paddr == `APSEQ_ADDR_CHARGE);
    assign pslverr = psel & penable & ~hit;   // Unmapped addresses answer with an error.
    assign wr_en   = psel & penable & pwrite;

    // Register writes; status addresses are read only and ignore writes.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            amplifier_control_ff <= `APSEQ_AMP_CTRL_RST;   // see R6
            prech_ff             <= `APSEQ_PRECH_RST;
            power_ff             <= `APSEQ_PWR_RST;
            reset_ff             <= `APSEQ_RST_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                `APSEQ_ADDR_AMP_CTRL: amplifier_control_ff <= pwdata[6:0];   // see R4
                `APSEQ_ADDR_PRECH:    prech_ff <= pwdata[7:0];   // see R15
                `APSEQ_ADDR_POWER:    power_ff <= pwdata[7:0];   // see R15
                `APSEQ_ADDR_RESET:    reset_ff <= pwdata[2:0];
                default:              reset_ff <= reset_ff;
            endcase
        end
    end

    // Power and fastcharge pairs of the seven charged blocks; the master
    // on bit lives in the fastcharge register beside the master fastcharge.
    assign chg_power = {power_ff[`APSEQ_PWR_PADRV], power_ff[`APSEQ_PWR_AUXIN],
                        power_ff[`APSEQ_PWR_LNOR], power_ff[`APSEQ_PWR_LNOL],
                        power_ff[`APSEQ_PWR_LNIR], power_ff[`APSEQ_PWR_LNIL],
                        prech_ff[`APSEQ_PRECH_ON_MSTR]};
    assign chg_fast  = {prech_ff[`APSEQ_PRECH_PADRV], prech_ff[`APSEQ_PRECH_AUXIN],
                        prech_ff[`APSEQ_PRECH_LNOR], prech_ff[`APSEQ_PRECH_LNOL],
                        prech_ff[`APSEQ_PRECH_LNIR], prech_ff[`APSEQ_PRECH_LNIL],
                        prech_ff[`APSEQ_PRECH_MSTR]};

    // One independent tracker per block, so any set may charge at once.
    genvar gi;
    generate
        for (gi = 0; gi < NBLK; gi = gi + 1)
        begin : g_chg
            apseq_charge u_chg   // see R16
            (
                .clk        (clk),
                .rst        (rst),
                .power_on   (chg_power[gi]),
                .fastcharge (chg_fast[gi]),
                .charging   (chg_busy[gi]),
                .ready      (chg_ready[gi])
            );
        end
    endgenerate

    // Gain code to dB in two's complement; code 0 equals the minimum.
    always @*
    begin
        if (amplifier_control_ff[3:0] == 4'h0)
            nxt_gain_db = `APSEQ_GAIN_MIN_DB;   // see R5
        else
            nxt_gain_db = `APSEQ_GAIN_TOP_DB
                        - (`APSEQ_GAIN_STEP_DB * {4'h0, amplifier_control_ff[3:0] - 4'h1});
    end

    // Amplifier outputs, registered so the analog side never sees a glitch
    // while the control word is being rewritten.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            amp_active      <= 1'b0;
            amp_precharging <= 1'b0;
            amp_high_power  <= 1'b0;
            amp_gain_code   <= 4'h0;
            amp_gain_db     <= `APSEQ_GAIN_MIN_DB;
            amp_forbidden   <= 1'b0;
        end
        else
        begin
            // The forbidden pair drives neither mode, protecting the amplifier.
            amp_active      <= amplifier_control_ff[`APSEQ_AMP_ON_BIT]
                             & ~amplifier_control_ff[`APSEQ_AMP_PRECH_BIT];   // see R1
            amp_precharging <= amplifier_control_ff[`APSEQ_AMP_PRECH_BIT]
                             & ~amplifier_control_ff[`APSEQ_AMP_ON_BIT];   // see R1
            amp_forbidden   <= amplifier_control_ff[`APSEQ_AMP_ON_BIT]
                             & amplifier_control_ff[`APSEQ_AMP_PRECH_BIT];   // see R2
            amp_high_power  <= amplifier_control_ff[`APSEQ_AMP_LP_BIT];   // see R3
            amp_gain_code   <= amplifier_control_ff[`APSEQ_AMP_GAIN_MSB:0];   // see R4
            amp_gain_db     <= nxt_gain_db;   // see R5
        end
    end

    // Block power and charge outputs. The converters have no charge state,
    // so they appear among the power enables only.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            block_power_en <= 8'h00;
            block_charging <= 6'h00;
        end
        else
        begin
            block_power_en <= {chg_power[6:1], power_ff[`APSEQ_PWR_DACR],
                               power_ff[`APSEQ_PWR_DACL]};   // see R15
            block_charging <= chg_busy[6:1];   // see R13
        end
    end

    // Codec reset pins; both resets stay asserted until software lifts them.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            codec_reset_n    <= 1'b0;
            filter_reset_n   <= 1'b0;
            codec_reset_mask <= 1'b0;
        end
        else
        begin
            codec_reset_n    <= reset_ff[`APSEQ_RST_CODEC_N];
            filter_reset_n   <= reset_ff[`APSEQ_RST_FILTER_N];
            codec_reset_mask <= reset_ff[`APSEQ_RST_MASK];
        end
    end

    // Read word selection; master charge state appears in the charge status word.
    always @*
    begin
        case (paddr)
            `APSEQ_ADDR_AMP_CTRL: nxt_prdata = {25'h0, amplifier_control_ff};
            `APSEQ_ADDR_PRECH:    nxt_prdata = {24'h0, prech_ff};
            `APSEQ_ADDR_POWER:    nxt_prdata = {24'h0, power_ff};
            `APSEQ_ADDR_RESET:    nxt_prdata = {29'h0, reset_ff};
            `APSEQ_ADDR_STATUS:   nxt_prdata = {23'h0, amp_forbidden, amp_gain_db};
            `APSEQ_ADDR_CHARGE:   nxt_prdata = {17'h0, chg_ready, 1'b0, chg_busy};   // see R14
            default:              nxt_prdata = 32'h0;
        endcase
    end

    // Read data is loaded in the setup phase, so it comes from a flop yet still
    // stands at the access edge with no wait state. A charge or status word is
    // therefore one cycle older than the access edge itself.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0;
        else if (psel && !penable)
            prdata <= nxt_prdata;
    end

endmodule

`default_nettype wire

// ===== verif/apseq_top_sva.sv
/* Assertions on the apseq_top pins, bound into every instance.
   Assumes a zero-wait APB and outputs that move two edges after a write. */
`timescale 1ns/1ps
`default_nettype none
module apseq_top_sva
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        amp_active,
    input wire logic        amp_precharging,
    input wire logic        amp_high_power,
    input wire logic [3:0]  amp_gain_code,
    input wire logic [7:0]  amp_gain_db,
    input wire logic        amp_forbidden,
    input wire logic [7:0]  block_power_en,
    input wire logic [5:0]  block_charging
);
    logic [31:0] wd1_ff;
    logic [31:0] wd2_ff;
    wire         wr_amp = psel && penable && pwrite && paddr == 12'h044;
    wire         wr_pwr = psel && penable && pwrite && paddr == 12'h000;
    // Write data is delayed two edges so that it meets the outputs it lands in.
    always @(posedge clk) wd1_ff <= pwdata;
    always @(posedge clk) wd2_ff <= wd1_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_amp_mode: assert property (
        wr_amp |-> ##2 {amp_active, amp_precharging} ==
        {wd2_ff[6] & ~wd2_ff[5], wd2_ff[5] & ~wd2_ff[6]}) else $error("amp mode wrong");
    a_forbid_flag: assert property (
        wr_amp |-> ##2 amp_forbidden == (wd2_ff[6] & wd2_ff[5])) else $error("forbid flag wrong");
    a_forbid_idle: assert property (
        amp_forbidden |-> !amp_active && !amp_precharging) else $error("forbidden not idle");
    a_power_level: assert property (
        wr_amp |-> ##2 amp_high_power == wd2_ff[4]) else $error("power level wrong");
    a_gain_code: assert property (
        wr_amp |-> ##2 amp_gain_code == wd2_ff[3:0]) else $error("gain code wrong");
    a_gain_table: assert property (
        $stable(amp_gain_code) |-> amp_gain_db == ((amp_gain_code == 4'h0) ? 8'hEA :
        8'h17 - 8'h03 * amp_gain_code)) else $error("gain in dB wrong");
    a_reset_state: assert property (
        $fell(rst) |-> {amp_active, amp_precharging, amp_high_power, amp_gain_code} == 7'h00)
        else $error("amp not cleared by reset");
    a_power_bits: assert property (
        wr_pwr |-> ##2 block_power_en == {wd2_ff[7:4], wd2_ff[1:0], wd2_ff[3:2]})
        else $error("power bits wrong");
    a_charge_drop: assert property (
        wr_pwr && !pwdata[7] |-> ##[3:4] !block_charging[5]) else $error("charge kept");
endmodule
bind apseq_top apseq_top_sva u_apseq_top_sva
(
    .clk             (clk),
    .rst             (rst),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .amp_active      (amp_active),
    .amp_precharging (amp_precharging),
    .amp_high_power  (amp_high_power),
    .amp_gain_code   (amp_gain_code),
    .amp_gain_db     (amp_gain_db),
    .amp_forbidden   (amp_forbidden),
    .block_power_en  (block_power_en),
    .block_charging  (block_charging)
);
`default_nettype wire

// ===== verif/tb_top.sv
/* Self-checking bench of apseq_top: random amplifier words and power sequences.
   Assumes APB access at byte addresses and a bound pin checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic        pready, pslverr, amp_active, amp_precharging, amp_high_power, amp_forbidden;
    logic        codec_reset_n, filter_reset_n, codec_reset_mask, er;
    logic [3:0]  amp_gain_code;
    logic [7:0]  amp_gain_db, block_power_en;
    logic [5:0]  block_charging;
    int          num_errors = 0, n_checks = 0, i;
    wire  [15:0] amp_pins = {amp_forbidden, amp_active, amp_precharging, amp_high_power,
                             amp_gain_code, amp_gain_db};
    apseq_top u_apseq_top
    (
        .clk              (clk),
        .rst              (rst),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pready           (pready),
        .prdata           (prdata),
        .pslverr          (pslverr),
        .amp_active       (amp_active),
        .amp_precharging  (amp_precharging),
        .amp_high_power   (amp_high_power),
        .amp_gain_code    (amp_gain_code),
        .amp_gain_db      (amp_gain_db),
        .amp_forbidden    (amp_forbidden),
        .block_power_en   (block_power_en),
        .block_charging   (block_charging),
        .codec_reset_n    (codec_reset_n),
        .filter_reset_n   (filter_reset_n),
        .codec_reset_mask (codec_reset_mask)
    );
    // Clock at 20 MHz.
    always #25 clk = ~clk;
    function automatic logic [7:0] exp_db(input logic [3:0] c);
        return (c == 4'h0) ? 8'hEA : 8'h17 - 8'h03 * c;
    endfunction
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    // The request stands until pready is seen high; an idle edge follows, so
    // a second call never drives psel twice in one time step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [39:0] e);
        apb(1'b0, a, 32'h0);
        chk("read", e, {er, rd});
    endtask
    task automatic amp(input logic [31:0] w);
        logic [15:0] e;
        apb(1'b1, 12'h044, w);
        @(posedge clk);
        e = {w[6] & w[5], w[6] & ~w[5], w[5] & ~w[6], w[4], w[3:0], exp_db(w[3:0])};
        chk("amp", e, amp_pins);
        rdc(12'h044, {25'h0, w[6:0]});
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // A hung handshake ends the run here.
    initial
    begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        v = $urandom(32'h50A7);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(12'h044, 32'h0);
        // Click-free start and stop: precharge, active, minimum gain, standby.
        amp(32'h20);
        amp(32'h51);
        amp(32'h4F);
        amp(32'h00);
        for (i = 0; i < 24; i++)
        begin
            v = $urandom;
            v[3:0] = i[3:0];
            v[6:5] = i[1:0];
            amp(v);
        end
        // The status word is read only, and an unmapped read must error.
        apb(1'b1, 12'h048, ~v);
        rdc(12'h048, {23'h0, v[6] & v[5], exp_db(v[3:0])});
        rdc(12'h100, {1'b1, 32'h0});
        apb(1'b1, 12'h040, 32'h07);
        apb(1'b1, 12'h030, 32'hFF);
        apb(1'b1, 12'h000, 32'h30);
        repeat (3) @(posedge clk);
        chk("chg", {6'h0C, 3'h7}, {block_charging, codec_reset_mask, filter_reset_n,
            codec_reset_n});
        apb(1'b1, 12'h030, 32'h01);
        apb(1'b1, 12'h000, 32'h3C);
        repeat (3) @(posedge clk);
        // Power pins run {driver, aux, line outs, line ins, right and left converter}.
        chk("pwr", {6'h00, 8'h33}, {block_charging, block_power_en});
        rdc(12'h04C, 32'h1900);
        // Power off, then power on again without fastcharge: nothing is ready.
        apb(1'b1, 12'h000, 32'h30);
        apb(1'b1, 12'h030, 32'h00);
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h030, 32'h01);
        apb(1'b1, 12'h000, 32'h30);
        repeat (3) @(posedge clk);
        rdc(12'h04C, 32'h0);
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h030, 32'hFF);
        apb(1'b1, 12'h000, 32'hFF);
        repeat (3) @(posedge clk);
        chk("all", 6'h3F, block_charging);
        // Dropping the driver's power in mid-charge ends its charge at once.
        apb(1'b1, 12'h000, 32'h7F);
        repeat (3) @(posedge clk);
        chk("drop", 6'h1F, block_charging);
        apb(1'b1, 12'h040, 32'hFFFFFFFA);
        rdc(12'h040, 32'h2);
        chk("rstpins", 3'h2, {codec_reset_mask, filter_reset_n, codec_reset_n});
        give_verdict();
    end
endmodule
`default_nettype wire
